// ---- rtl/eeprom_cmd_ctrl.sv ----
// serial eeprom command controller with apb register slave
// Function
// - writing one to busy runs the chosen command; busy holds until done.
// - write with no memory and return line low keeps busy until time-out, then clears.
// - busy reads high after reset until automatic load finishes or fails.
// - three-bit command code decodes eight commands; resets to read.
// - read fetches addressed byte into data register.
// - write stores data byte at addressed location when unlocked.
// - fill-all stores data byte into every location when unlocked.
// - erase clears one location, bulk erase clears all, when unlocked.
// - reload rereads config; first byte not A5 means failed reload.
// - failed reload leaves loaded configuration unchanged.
// - no response within 30 ms returns idle and sets time-out flag.
// - return line high and no memory: no time-out, busy clears at end.
// - return line low and no memory: only erase/write kinds time out.
// - load-done flag set on good load; software write of one clears; resets zero.
// - nine-bit byte address for read, write and erase, resets to zero.
// - data register low byte holds memory byte; upper bits read zero.
// - registers stay accessible while system clock is off.
`timescale 1ns/10ps
module eeprom_cmd_ctrl
   import eeprom_ctrl_pkg::*;
#(
   parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
   input wire logic pclk, // apb clock, free running
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [15:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   output logic mem_cs, // memory chip select
   output logic mem_sclk, // memory serial clock
   output logic mem_sdo, // data towards memory
   input wire logic serial_return_line, // data from memory
   output logic [LOAD_WORDS*8-1:0] loaded_config // configuration bytes from memory
);
   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_WAIT, ST_LOAD_NEXT, ST_LOAD_WAIT} ctl_state_t;

   initial begin
      if (TIMEOUT_LIMIT < 1) $error("timeout limit must be positive");
   end

   ctl_state_t state_reg;
   logic busy_reg;
   command_code_t code_reg;
   logic timeout_reg;
   logic loaded_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg;
   logic [LOAD_WORDS*8-1:0] shadow_reg;
   logic [1:0] load_idx_reg;
   logic sig_ok_reg;

   frame_req_t req_next;
   logic sh_start_reg;
   frame_req_t req_reg;
   logic sh_done;
   logic sh_ready;
   logic [DATA_W-1:0] sh_rd;
   logic to_expired;
   logic to_restart;
   logic to_run;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic acc;
   logic hit_cmd;
   logic hit_data;
   logic wr_cmd;
   logic wr_data;
   logic start_cmd;
   assign acc = psel && penable;
   assign hit_cmd = (paddr == CMD_REG_OFFSET);
   assign hit_data = (paddr == DATA_REG_OFFSET);
   assign wr_cmd = acc && pwrite && hit_cmd && pready;
   assign wr_data = acc && pwrite && hit_data && pready;
   assign start_cmd = wr_cmd && pwdata[BUSY_BIT] && !busy_reg;

   // bus runs on pclk, independent of the gated system clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(hit_cmd || hit_data);
         if (psel && !penable && !pwrite) begin
            if (hit_cmd) begin
               prdata <= {busy_reg, code_reg, 17'h00000, timeout_reg, loaded_reg, addr_reg};
            end else if (hit_data) begin
               prdata <= {24'h000000, data_reg};
            end else begin
               prdata <= '0;
            end
         end
      end
   end

   // ----------------------------------------
   // software fields
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_reg <= command_code_t'(CODE_RESET);
         addr_reg <= ADDR_RESET;
      end else if (wr_cmd && !busy_reg) begin
         code_reg <= command_code_t'(pwdata[CODE_LSB +: 3]);
         addr_reg <= pwdata[ADDR_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg <= DATA_RESET;
      end else if (state_reg == ST_WAIT && sh_done && code_reg == CMD_READ) begin
         data_reg <= sh_rd;
      end else if (wr_data && !busy_reg) begin
         data_reg <= pwdata[DATA_W-1:0];
      end
   end

   // ----------------------------------------
   // frame request builder
   // ----------------------------------------
   always_comb begin
      req_next = '0;
      req_next.addr = addr_reg;
      req_next.data = data_reg;
      unique case (code_reg)
         // read clocks eight data bits back in
         CMD_READ: begin
            req_next.start_op = 2'h2;
            req_next.has_data = 1'b1;
         end
         CMD_LOCK: req_next.addr = 9'h000;
         CMD_UNLOCK: req_next.addr = 9'h180;
         CMD_WRITE: begin
            req_next.start_op = 2'h1;
            req_next.has_data = 1'b1;
            req_next.wait_ready = 1'b1;
         end
         CMD_FILL_ALL: begin
            req_next.addr = 9'h080;
            req_next.has_data = 1'b1;
            req_next.wait_ready = 1'b1;
         end
         CMD_ERASE: begin
            req_next.start_op = 2'h3;
            req_next.wait_ready = 1'b1;
         end
         CMD_BULK_ERASE: begin
            req_next.addr = 9'h100;
            req_next.wait_ready = 1'b1;
         end
         CMD_RELOAD: begin
            req_next.start_op = 2'h2;
            req_next.addr = 9'h000;
         end
      endcase
      if (state_reg == ST_LOAD_NEXT) begin
         req_next = '0;
         req_next.start_op = 2'h2;
         req_next.addr = 9'(load_idx_reg);
         req_next.has_data = 1'b1;
      end
   end

   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_LOAD_NEXT;
         busy_reg <= 1'b1;
         sh_start_reg <= 1'b0;
         req_reg <= '0;
         load_idx_reg <= '0;
         sig_ok_reg <= 1'b0;
      end else begin
         sh_start_reg <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (start_cmd) begin
                  busy_reg <= 1'b1;
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (code_reg == CMD_RELOAD) begin
                  load_idx_reg <= '0;
                  state_reg <= ST_LOAD_NEXT;
               end else begin
                  req_reg <= req_next;
                  sh_start_reg <= 1'b1;
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (to_expired || sh_done) begin
                  busy_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_LOAD_NEXT: begin
               req_reg <= req_next;
               sh_start_reg <= 1'b1;
               state_reg <= ST_LOAD_WAIT;
            end
            ST_LOAD_WAIT: begin
               if (sh_done) begin
                  if (load_idx_reg == 2'h0) begin
                     sig_ok_reg <= (sh_rd == VALID_SIGNATURE);
                  end
                  if ((load_idx_reg == 2'h0 && sh_rd != VALID_SIGNATURE) ||
                      load_idx_reg == 2'(LOAD_WORDS - 1)) begin
                     busy_reg <= 1'b0;
                     state_reg <= ST_IDLE;
                  end else begin
                     load_idx_reg <= load_idx_reg + 1'b1;
                     state_reg <= ST_LOAD_NEXT;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // shadow only committed after full valid load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_reg <= '0;
         loaded_config <= '0;
      end else begin
         if (state_reg == ST_LOAD_WAIT && sh_done) begin
            shadow_reg[load_idx_reg*8 +: 8] <= sh_rd;
         end
         if (state_reg == ST_LOAD_WAIT && sh_done && sig_ok_reg &&
             load_idx_reg == 2'(LOAD_WORDS - 1)) begin
            loaded_config <= {sh_rd, shadow_reg[(LOAD_WORDS-1)*8-1:0]};
         end
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_reg <= 1'b0;
      end else if (state_reg == ST_WAIT && to_expired) begin
         timeout_reg <= 1'b1;
      end else if (start_cmd) begin
         timeout_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_reg <= 1'b0;
      end else if (state_reg == ST_LOAD_WAIT && sh_done && sig_ok_reg &&
                   load_idx_reg == 2'(LOAD_WORDS - 1)) begin
         loaded_reg <= 1'b1;
      end else if (wr_cmd && pwdata[LOADED_BIT]) begin
         loaded_reg <= 1'b0;
      end
   end

   assign to_restart = sh_start_reg;
   assign to_run = (state_reg == ST_WAIT);

   eeprom_timeout_counter #(
      .LIMIT(TIMEOUT_LIMIT)
   ) u_timeout (
      .pclk(pclk),
      .presetn(presetn),
      .restart(to_restart),
      .run(to_run),
      .expired(to_expired)
   );

   eeprom_serial_shifter u_shifter (
      .pclk(pclk),
      .presetn(presetn),
      .start(sh_start_reg),
      .req(req_reg),
      .abort(state_reg == ST_WAIT && to_expired),
      .done(sh_done),
      .ready_seen(),
      .rd_data(sh_rd),
      .cs(mem_cs),
      .sclk(mem_sclk),
      .sdo(mem_sdo),
      .serial_return_line(serial_return_line)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   busy_after_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_cmd |=> busy_reg ##1 busy_reg)
      else $error("busy not held after command start");

   timeout_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_WAIT && to_expired) |=> (timeout_reg && !busy_reg && state_reg == ST_IDLE))
      else $error("time-out did not return to idle with flag");

   timeout_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_cmd |=> !timeout_reg)
      else $error("time-out flag not cleared at start");

   read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_WAIT && sh_done && code_reg == CMD_READ) |=> data_reg == $past(sh_rd))
      else $error("read byte not captured");

   load_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(loaded_reg) |-> $fell(busy_reg) && sig_ok_reg)
      else $error("load flag set without valid load");

   failed_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(state_reg == ST_LOAD_WAIT && sh_done && sig_ok_reg && load_idx_reg == 2'(LOAD_WORDS - 1))
      |=> $stable(loaded_config))
      else $error("configuration changed without valid load");

   upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_data) |=> prdata[31:8] == 24'h000000)
      else $error("data register upper bits not zero");

   no_change_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
      busy_reg |=> $stable(addr_reg))
      else $error("address changed while busy");

endmodule : eeprom_cmd_ctrl

// ---- rtl/eeprom_ctrl_pkg.sv ----
// shared constants and types for the serial eeprom command controller
package eeprom_ctrl_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [15:0] CMD_REG_OFFSET = 16'h6000;
   localparam logic [15:0] DATA_REG_OFFSET = 16'h6004;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BUSY_BIT = 31;
   localparam int CODE_LSB = 28;
   localparam int TIMEOUT_BIT = 10;
   localparam int LOADED_BIT = 9;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;

   // ----------------------------------------
   // reset values and constants
   // ----------------------------------------
   localparam logic [2:0] CODE_RESET = 3'h0;
   localparam logic [8:0] ADDR_RESET = 9'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] VALID_SIGNATURE = 8'hA5;
   localparam int LOAD_WORDS = 4;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIMEOUT_MS = 30;
   localparam int TIMEOUT_CYCLES = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYCLES = 2;
   localparam int CS_GAP_CYCLES = 2;

   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_LOCK = 3'h1,
      CMD_UNLOCK = 3'h2,
      CMD_WRITE = 3'h3,
      CMD_FILL_ALL = 3'h4,
      CMD_ERASE = 3'h5,
      CMD_BULK_ERASE = 3'h6,
      CMD_RELOAD = 3'h7
   } command_code_t;

   // one serial frame request to the shifter
   typedef struct packed {
      logic [1:0] start_op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic has_data;
      logic wait_ready;
   } frame_req_t;

endpackage : eeprom_ctrl_pkg

// ---- rtl/eeprom_serial_shifter.sv ----
// serial frame engine: start bit, opcode, address, optional data, ready poll
`timescale 1ns/10ps
module eeprom_serial_shifter
   import eeprom_ctrl_pkg::*;
(
   input wire logic pclk, // apb clock
   input wire logic presetn, // async reset, active low
   input wire logic start, // begin a frame, one-cycle pulse
   input wire frame_req_t req, // frame contents
   input wire logic abort, // drop frame at once
   output logic done, // frame complete, one-cycle pulse
   output logic ready_seen, // ready poll saw high line
   output logic [DATA_W-1:0] rd_data, // shifted-in byte
   output logic cs, // memory chip select
   output logic sclk, // memory serial clock
   output logic sdo, // data towards memory
   input wire logic serial_return_line // data from memory
);
   localparam int BITS = 3 + ADDR_W + DATA_W;
   typedef enum logic [1:0] {SH_IDLE, SH_SHIFT, SH_POLL, SH_GAP} sh_state_t;

   sh_state_t state_reg;
   logic [BITS-1:0] out_reg;
   logic [4:0] bits_left_reg;
   logic [1:0] div_reg;
   logic poll_reg;

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SH_IDLE;
         out_reg <= '0;
         bits_left_reg <= '0;
         div_reg <= '0;
         poll_reg <= 1'b0;
         cs <= 1'b0;
         sclk <= 1'b0;
         sdo <= 1'b0;
         done <= 1'b0;
         ready_seen <= 1'b0;
         rd_data <= '0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            state_reg <= SH_IDLE;
            cs <= 1'b0;
            sclk <= 1'b0;
         end else begin
            unique case (state_reg)
               SH_IDLE: begin
                  if (start) begin
                     out_reg <= {1'b1, req.start_op, req.addr, req.data};
                     bits_left_reg <= req.has_data ? 5'(BITS) : 5'(BITS - DATA_W);
                     poll_reg <= req.wait_ready;
                     ready_seen <= 1'b0;
                     div_reg <= '0;
                     cs <= 1'b1;
                     state_reg <= SH_SHIFT;
                  end
               end
               SH_SHIFT: begin
                  div_reg <= div_reg + 1'b1;
                  if (div_reg == 2'(SCLK_HALF_CYCLES - 1)) begin
                     sdo <= out_reg[BITS-1];
                  end else if (div_reg == 2'(2 * SCLK_HALF_CYCLES - 1)) begin
                     sclk <= 1'b0;
                     // count was already lowered on the rising half, so zero means the last bit went out
                     if (bits_left_reg == 5'h00) begin
                        state_reg <= poll_reg ? SH_POLL : SH_GAP;
                        cs <= poll_reg;
                        div_reg <= '0;
                     end
                  end else if (div_reg == 2'(SCLK_HALF_CYCLES)) begin
                     // sample return line on rising sclk
                     sclk <= 1'b1;
                     out_reg <= {out_reg[BITS-2:0], 1'b0};
                     rd_data <= {rd_data[DATA_W-2:0], serial_return_line};
                     bits_left_reg <= bits_left_reg - 1'b1;
                  end
               end
               SH_POLL: begin
                  if (serial_return_line) begin
                     ready_seen <= 1'b1;
                     cs <= 1'b0;
                     state_reg <= SH_GAP;
                  end
               end
               SH_GAP: begin
                  cs <= 1'b0;
                  div_reg <= div_reg + 1'b1;
                  if (div_reg == 2'(CS_GAP_CYCLES - 1)) begin
                     done <= 1'b1;
                     state_reg <= SH_IDLE;
                  end
               end
               default: state_reg <= SH_IDLE;
            endcase
         end
      end
   end
endmodule : eeprom_serial_shifter

// ---- rtl/eeprom_timeout_counter.sv ----
// down counter that flags a missing response from the serial memory
`timescale 1ns/10ps
module eeprom_timeout_counter
   import eeprom_ctrl_pkg::*;
#(
   parameter int LIMIT = TIMEOUT_CYCLES
) (
   input wire logic pclk, // apb clock
   input wire logic presetn, // async reset, active low
   input wire logic restart, // reload count
   input wire logic run, // count while high
   output logic expired // limit reached, one-cycle pulse
);
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] count_reg;

   initial begin
      if (LIMIT < 1) $error("timeout limit must be at least one cycle");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else if (restart) begin
         count_reg <= CW'(LIMIT);
      end else if (run && count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expired <= 1'b0;
      end else begin
         expired <= run && !restart && (count_reg == CW'(1));
      end
   end
endmodule : eeprom_timeout_counter

// ---- verif/eeprom_model.sv ----
// behavioural serial memory at the far side of the controller
`timescale 1ns/10ps
module eeprom_model (
   input wire logic cs, // select
   input wire logic sclk, // serial clock
   input wire logic sdo, // data from controller
   input wire logic absent, // no memory fitted
   input wire logic idle_level, // pulled line level
   output logic serial_return_line // data to controller
);
   logic [7:0] mem [512];
   logic [19:0] sr = '0;
   logic [8:0] ra = '0;
   logic dout = 1'b1;
   logic unl = 1'b0;
   int cnt = 0;
   int rd = -1;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // missing memory leaves the pulled level
   // deselected memory floats its output, so the pull level shows
   assign serial_return_line = (absent || !cs) ? idle_level : dout;
   always @(negedge cs) begin
      cnt = 0;
      rd = -1;
      dout = 1'b1;
   end
   // frame bits taken on rising clock, leading zeros skipped
   always @(posedge sclk) begin
      if (cs && !absent && (cnt > 0 || sdo)) begin
         sr = {sr[18:0], sdo};
         cnt++;
         if (cnt == 12) exec(sr[10:9], sr[8:0], 1'b0);
         if (cnt == 20) exec(sr[18:17], sr[16:8], 1'b1);
      end
   end
   // erase and write honoured only when unlocked
   task automatic exec(input logic [1:0] op, input logic [8:0] a, input logic full);
      if (op == 2'b10 && !full) begin
         ra = a;
         rd = 8;
      end
      if (op == 2'b11 && !full && unl) mem[a] = 8'hFF;
      if (op == 2'b01 && full && unl) mem[a] = sr[7:0];
      if (op == 2'b00 && !full && a[8:7] == 2'b00) unl = 1'b0;
      if (op == 2'b00 && !full && a[8:7] == 2'b11) unl = 1'b1;
      if (op == 2'b00 && !full && a[8:7] == 2'b10 && unl) foreach (mem[i]) mem[i] = 8'hFF;
      if (op == 2'b00 && full && a[8:7] == 2'b01 && unl) foreach (mem[i]) mem[i] = sr[7:0];
   endtask : exec
   // past the byte the line toggles so stale data never looks valid
   always @(negedge sclk) begin
      if (rd > 0) begin
         rd--;
         dout = mem[ra][rd];
      end else if (rd == 0) dout = ~dout;
   end
endmodule : eeprom_model

// ---- verif/tb.sv ----
// self-checking bench for the serial eeprom command controller
`timescale 1ns/10ps
module tb;
   import eeprom_ctrl_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, mem_cs, mem_sclk, mem_sdo;
   logic serial_return_line, absent, idle_level, e;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, r, seed, cfg;
   logic [LOAD_WORDS*8-1:0] loaded_config;
   logic [7:0] d;
   logic [8:0] a;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   always #50 pclk = ~pclk;
   // limit must exceed one full frame, or commands with a live memory would expire
   eeprom_cmd_ctrl #(.TIMEOUT_LIMIT(200)) dut (.*);
   eeprom_model m (.cs(mem_cs), .sclk(mem_sclk), .sdo(mem_sdo), .absent(absent), .idle_level(idle_level),
      .serial_return_line(serial_return_line));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, x, g);
      end
   endtask : check
   // one idle edge after release so psel is never assigned twice at once
   task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic idle();
      do apb(1'b0, CMD_REG_OFFSET, '0); while (r[BUSY_BIT] !== 1'b0);
   endtask : idle
   // next command only after busy clears
   task automatic run(input logic [2:0] c, input logic [8:0] ad);
      apb(1'b1, CMD_REG_OFFSET, {1'b1, c, 19'h0, ad});
      idle();
   endtask : run
   task automatic rd_byte(input logic [8:0] ad, input logic [7:0] x);
      run(CMD_READ, ad);
      apb(1'b0, DATA_REG_OFFSET, '0);
      check("read byte", {24'h0, x}, r);
   endtask : rd_byte
   function automatic logic times_out(input logic [2:0] c);
      return c inside {CMD_WRITE, CMD_FILL_ALL, CMD_ERASE, CMD_BULK_ERASE};
   endfunction : times_out
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 100000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      absent = 1'b0;
      idle_level = 1'b1;
      seed = $urandom(32'hFF38A45A);
      repeat (2) @(posedge pclk);
      m.mem[0] = VALID_SIGNATURE;
      for (int i = 1; i < 4; i++) m.mem[i] = 8'($urandom);
      cfg = {m.mem[3], m.mem[2], m.mem[1], VALID_SIGNATURE};
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, CMD_REG_OFFSET, '0);
      check("busy at start", 32'h1, 32'(r[BUSY_BIT]));
      idle();
      check("command reset", 32'h200, r & 32'h700007FF);
      check("config", cfg, loaded_config);
      apb(1'b0, DATA_REG_OFFSET, '0);
      check("data reset", 32'h0, r);
      apb(1'b0, 16'h6008, '0);
      check("unmapped error", 32'h1, 32'(e));
      $display("test reset done");
      run(CMD_UNLOCK, 9'h0);
      for (int k = 0; k < 4; k++) begin
         a = (k == 0) ? 9'h1FF : 9'($urandom);
         d = 8'($urandom);
         apb(1'b1, DATA_REG_OFFSET, {24'($urandom), d});
         run(CMD_WRITE, a);
         rd_byte(a, d);
      end
      run(CMD_LOCK, 9'h0);
      apb(1'b1, DATA_REG_OFFSET, {24'h0, ~d});
      run(CMD_WRITE, a);
      rd_byte(a, d);
      run(CMD_UNLOCK, 9'h0);
      run(CMD_ERASE, a);
      rd_byte(a, 8'hFF);
      apb(1'b1, DATA_REG_OFFSET, {24'h0, d});
      run(CMD_FILL_ALL, 9'h0);
      rd_byte(9'($urandom), d);
      run(CMD_BULK_ERASE, 9'h0);
      rd_byte(9'h000, 8'hFF);
      $display("test memory commands done");
      apb(1'b1, CMD_REG_OFFSET, 32'h200);
      apb(1'b0, CMD_REG_OFFSET, '0);
      check("load done clear", 32'h0, 32'(r[LOADED_BIT]));
      run(CMD_RELOAD, 9'h0);
      check("failed reload", 32'h0, 32'(r[LOADED_BIT]));
      check("config kept", cfg, loaded_config);
      absent <= 1'b1;
      idle_level <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         run(3'(c), 9'h0);
         check("low line timeout", 32'(times_out(3'(c))), 32'(r[TIMEOUT_BIT]));
      end
      idle_level <= 1'b1;
      run(CMD_WRITE, 9'h0);
      check("high line timeout", 32'h0, 32'(r[TIMEOUT_BIT]));
      $display("test missing memory done");
      absent <= 1'b0;
      run(CMD_UNLOCK, 9'h0);
      apb(1'b1, DATA_REG_OFFSET, {24'h0, VALID_SIGNATURE});
      run(CMD_WRITE, 9'h0);
      run(CMD_RELOAD, 9'h0);
      check("reload flag", 32'h1, 32'(r[LOADED_BIT]));
      check("reload config", {24'hFFFFFF, VALID_SIGNATURE}, loaded_config);
      $display("test reload done");
      end_of_test();
   end
endmodule : tb
